// ### design/ufci_pkg.sv
// Constants and carrier types for the FIFO control and interrupt identification block
package ufci_pkg;

    // Characters held by each of the receive and transmit FIFOs
    localparam int UFCI_FIFO_DEPTH = 16;

    // Register addresses on the host register bus
    localparam logic [2:0] UFCI_ADDR_DATA = 3'h0;
    localparam logic [2:0] UFCI_ADDR_IE = 3'h1;
    localparam logic [2:0] UFCI_ADDR_FCTL = 3'h2;
    localparam logic [2:0] UFCI_ADDR_LS = 3'h5;
    localparam logic [2:0] UFCI_ADDR_MS = 3'h6;

    // Field positions in fifo_control
    localparam int UFCI_FC_ENABLE = 0;
    localparam int UFCI_FC_RX_CLR = 1;
    localparam int UFCI_FC_TX_CLR = 2;
    localparam int UFCI_FC_DMA = 3;
    localparam int UFCI_FC_TRIG_LO = 6;
    localparam int UFCI_FC_TRIG_HI = 7;

    // Field positions in interrupt_enable
    localparam int UFCI_IE_RDA = 0;
    localparam int UFCI_IE_THRE = 1;
    localparam int UFCI_IE_LS = 2;
    localparam int UFCI_IE_MS = 3;

    // Receive trigger levels in characters
    localparam logic [4:0] UFCI_TRIG_1 = 5'h01;
    localparam logic [4:0] UFCI_TRIG_4 = 5'h04;
    localparam logic [4:0] UFCI_TRIG_8 = 5'h08;
    localparam logic [4:0] UFCI_TRIG_14 = 5'h0E;

    // Low nibble codes of interrupt_identification
    localparam logic [3:0] UFCI_ID_NONE = 4'h1;
    localparam logic [3:0] UFCI_ID_LS = 4'h6;
    localparam logic [3:0] UFCI_ID_RDA = 4'h4;
    localparam logic [3:0] UFCI_ID_TMO = 4'hC;
    localparam logic [3:0] UFCI_ID_THRE = 4'h2;
    localparam logic [3:0] UFCI_ID_MS = 4'h0;

    // Character times of receive silence before a timeout
    localparam logic [2:0] UFCI_TMO_CHARS = 3'h4;

    // Reset values
    localparam logic [3:0] UFCI_IE_RESET = 4'h0;
    localparam logic [1:0] UFCI_TRIG_RESET = 2'h0;
    localparam logic [7:0] UFCI_IID_RESET = 8'h01;
    localparam logic [7:0] UFCI_BYTE_ZERO = 8'h00;

    // Character delivered by the receive shifter with its line errors
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic parity_err;
        logic framing_err;
        logic break_det;
    } ufci_rx_char_s;

    // Modem line levels and change events
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] delta;
    } ufci_modem_s;

    // Character offered to the transmit shifter
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ufci_tx_char_s;

endpackage

// ### design/ufci_fifo_ctrl_irq_ident.sv
// FIFO control, receive and transmit FIFOs and interrupt identification logic
// Notes on behaviour
// - Bits 7:6 pick trigger 1, 4, 8, 14
// - Address 2 writes control, reads identification
// - Receive ready while receive FIFO nonempty
// - Transmit ready while transmit FIFO empty
// - Bit 2 empties transmit FIFO, self-clearing
// - Bit 1 empties receive FIFO, self-clearing
// - Bit 0 selects FIFO or legacy mode
// - Other bits ignored unless bit 0 set
// - Five interrupt priority levels, line status highest
// - Identification frozen during its read
// - Bits 7:6 show enable, 5:4 zero
// - Bits 3:1 encode source, bit 3 FIFO-only
// - Bit 0 low when interrupt pending
// - Line status errors report 0110
// - Data available or trigger reports 0100
// - Receive timeout after four idle characters, 1100
// - Transmit empty 0010, cleared by read/write
// - Modem status changes report 0000
// - Disabled sources never flag nor interrupt
`timescale 1ns/1ps

module ufci_fifo_ctrl_irq_ident
    import ufci_pkg::*;
#(
    parameter int DEPTH = UFCI_FIFO_DEPTH
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire ufci_rx_char_s rx_char_in,
    input wire ufci_modem_s modem_in,
    input wire logic char_tick_in,
    input wire logic tx_take_in,
    output ufci_tx_char_s tx_char_out,
    output logic receive_ready_out,
    output logic transmit_ready_out,
    output logic host_interrupt_out
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_ZERO = CW'(0);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [PW-1:0] PTR_ZERO = PW'(0);

    // Whole state of the block
    typedef struct packed {
        logic [DEPTH-1:0][7:0] rx_mem;
        logic [DEPTH-1:0][7:0] tx_mem;
        logic [PW-1:0] rx_rd;
        logic [PW-1:0] rx_wr;
        logic [PW-1:0] tx_rd;
        logic [PW-1:0] tx_wr;
        logic [CW-1:0] rx_cnt;
        logic [CW-1:0] tx_cnt;
        logic fifo_en;
        logic [1:0] trig_sel;
        logic [3:0] ie;
        logic overrun;
        logic parity;
        logic framing;
        logic brk;
        logic [3:0] ms_delta;
        logic thre_pend;
        logic [2:0] tmo_cnt;
        logic [7:0] iid;
        logic [7:0] rdata;
        logic rx_rdy;
        logic tx_rdy;
        logic irq;
        logic tx_valid;
        logic [7:0] tx_data;
    } ufci_state_s;

    ufci_state_s s_r;
    ufci_state_s s_nxt;

    logic data_rd;
    logic data_wr;
    logic ie_wr;
    logic fc_wr;
    logic iid_rd;
    logic ls_rd;
    logic ms_rd;
    logic [CW-1:0] limit;
    logic [CW-1:0] trig_cnt;
    logic rx_pop;
    logic rx_push;
    logic tx_push;
    logic tx_pop;
    logic rx_clr;
    logic tx_clr;
    logic src_ls;
    logic src_rda;
    logic src_tmo;
    logic src_thre;
    logic src_ms;
    logic thre_now;
    logic thre_next;
    logic thre_clr;
    logic [3:0] id_code;

    // Pointer advance with wrap at the last slot
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PTR_LAST) ? PTR_ZERO : p + PW'(1);
    endfunction

    // Occupancy after one cycle of pushes and pops
    function automatic logic [CW-1:0] cnt_step(
        input logic [CW-1:0] cnt,
        input logic push,
        input logic pop
    );
        if (push && !pop) begin
            cnt_step = cnt + CNT_ONE;
        end else if (pop && !push) begin
            cnt_step = cnt - CNT_ONE;
        end else begin
            cnt_step = cnt;
        end
    endfunction

    // True while a FIFO count shows no characters
    function automatic logic cnt_empty(input logic [CW-1:0] cnt);
        cnt_empty = (cnt == CNT_ZERO);
    endfunction

    // Sticky flag; a new event beats a clear in the same cycle
    function automatic logic sticky(input logic held, input logic clr, input logic set);
        sticky = (held && !clr) || set;
    endfunction

    // Strobe qualified by one register address
    function automatic logic addr_hit(
        input logic strobe,
        input logic [2:0] a,
        input logic [2:0] t
    );
        addr_hit = strobe && (a == t);
    endfunction

    // Transmit-empty condition as seen through its enable
    function automatic logic thre_cond(input ufci_state_s st);
        thre_cond = st.ie[UFCI_IE_THRE] && cnt_empty(st.tx_cnt);
    endfunction

    // Line status byte as the host reads it
    function automatic logic [7:0] ls_byte(input ufci_state_s st);
        ls_byte = {1'b0, cnt_empty(st.tx_cnt), cnt_empty(st.tx_cnt), st.brk, st.framing,
                   st.parity, st.overrun, !cnt_empty(st.rx_cnt)};
    endfunction

    // Identification byte: mode copy twice, two zero bits, source code
    function automatic logic [7:0] iid_byte(input logic en, input logic [3:0] code);
        logic [3:0] c;
        c = code;
        if (!en) begin
            c[3] = 1'b0;
        end
        iid_byte = {en, en, 2'b00, c};
    endfunction

    // Receive trigger level in characters for a select code
    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        case (sel)
            2'h0: trig_level = UFCI_TRIG_1;
            2'h1: trig_level = UFCI_TRIG_4;
            2'h2: trig_level = UFCI_TRIG_8;
            default: trig_level = UFCI_TRIG_14;
        endcase
    endfunction

    // Highest-priority pending source, line status first
    function automatic logic [3:0] prio_code(
        input logic ls,
        input logic rda,
        input logic tmo,
        input logic thre,
        input logic ms
    );
        if (ls) begin
            prio_code = UFCI_ID_LS;
        end else if (rda) begin
            prio_code = UFCI_ID_RDA;
        end else if (tmo) begin
            prio_code = UFCI_ID_TMO;
        end else if (thre) begin
            prio_code = UFCI_ID_THRE;
        end else if (ms) begin
            prio_code = UFCI_ID_MS;
        end else begin
            prio_code = UFCI_ID_NONE;
        end
    endfunction

    // Bus decode, FIFO movement and interrupt evaluation
    always_comb begin
        s_nxt = s_r;

        // Address decode; address 2 splits by direction
        data_rd = addr_hit(rd_in, addr_in, UFCI_ADDR_DATA);
        data_wr = addr_hit(wr_in, addr_in, UFCI_ADDR_DATA);
        ie_wr = addr_hit(wr_in, addr_in, UFCI_ADDR_IE);
        fc_wr = addr_hit(wr_in, addr_in, UFCI_ADDR_FCTL);
        iid_rd = addr_hit(rd_in, addr_in, UFCI_ADDR_FCTL);
        ls_rd = addr_hit(rd_in, addr_in, UFCI_ADDR_LS);
        ms_rd = addr_hit(rd_in, addr_in, UFCI_ADDR_MS);

        // Legacy mode behaves as a one-character holding register
        limit = s_r.fifo_en ? CNT_FULL : CNT_ONE;

        // FIFO control write; bit 3 is never looked at
        rx_clr = 1'b0;
        tx_clr = 1'b0;
        if (fc_wr) begin
            s_nxt.fifo_en = wdata_in[UFCI_FC_ENABLE];
            if (wdata_in[UFCI_FC_ENABLE]) begin
                s_nxt.trig_sel = wdata_in[UFCI_FC_TRIG_HI:UFCI_FC_TRIG_LO];
                rx_clr = wdata_in[UFCI_FC_RX_CLR] || !s_r.fifo_en;
                tx_clr = wdata_in[UFCI_FC_TX_CLR] || !s_r.fifo_en;
            end else begin
                rx_clr = 1'b1;
                tx_clr = 1'b1;
            end
        end

        // Receive FIFO: shifter pushes, host reads pop
        rx_pop = data_rd && (s_r.rx_cnt != CNT_ZERO);
        rx_push = rx_char_in.valid && ((s_r.rx_cnt < limit) || rx_pop);
        if (rx_clr) begin
            s_nxt.rx_rd = PTR_ZERO;
            s_nxt.rx_wr = PTR_ZERO;
            s_nxt.rx_cnt = CNT_ZERO;
        end else begin
            if (rx_push) begin
                s_nxt.rx_mem[s_r.rx_wr] = rx_char_in.data;
                s_nxt.rx_wr = ptr_inc(s_r.rx_wr);
            end
            if (rx_pop) begin
                s_nxt.rx_rd = ptr_inc(s_r.rx_rd);
            end
            s_nxt.rx_cnt = cnt_step(s_r.rx_cnt, rx_push, rx_pop);
        end

        // Transmit FIFO: host writes push, shifter takes pop
        tx_push = data_wr && (s_r.tx_cnt < limit);
        tx_pop = s_r.tx_valid && tx_take_in;
        if (tx_clr) begin
            s_nxt.tx_rd = PTR_ZERO;
            s_nxt.tx_wr = PTR_ZERO;
            s_nxt.tx_cnt = CNT_ZERO;
        end else begin
            if (tx_push) begin
                s_nxt.tx_mem[s_r.tx_wr] = wdata_in;
                s_nxt.tx_wr = ptr_inc(s_r.tx_wr);
            end
            if (tx_pop) begin
                s_nxt.tx_rd = ptr_inc(s_r.tx_rd);
            end
            s_nxt.tx_cnt = cnt_step(s_r.tx_cnt, tx_push, tx_pop);
        end

        // Interrupt enable write
        if (ie_wr) begin
            s_nxt.ie = wdata_in[3:0];
        end

        // Line errors are sticky; a new event beats the clearing read
        s_nxt.overrun = sticky(s_r.overrun, ls_rd, rx_char_in.valid && !rx_push && !rx_clr);
        s_nxt.parity = sticky(s_r.parity, ls_rd, rx_char_in.valid && rx_char_in.parity_err);
        s_nxt.framing = sticky(s_r.framing, ls_rd, rx_char_in.valid && rx_char_in.framing_err);
        s_nxt.brk = sticky(s_r.brk, ls_rd, rx_char_in.valid && rx_char_in.break_det);

        // Modem change flags, cleared by reading modem status
        s_nxt.ms_delta = (s_r.ms_delta & ~{4{ms_rd}}) | modem_in.delta;

        // Character times without FIFO activity while data waits
        if (!s_nxt.fifo_en || rx_push || rx_pop || rx_clr || (s_nxt.rx_cnt == CNT_ZERO)) begin
            s_nxt.tmo_cnt = 3'h0;
        end else if (char_tick_in && (s_r.tmo_cnt < UFCI_TMO_CHARS)) begin
            s_nxt.tmo_cnt = s_r.tmo_cnt + 3'h1;
        end

        // Transmit-empty event latches on the rising edge of its condition
        thre_now = thre_cond(s_r);
        thre_next = thre_cond(s_nxt);
        thre_clr = tx_push || (iid_rd && (s_r.iid[3:0] == UFCI_ID_THRE)) ||
                   !s_nxt.ie[UFCI_IE_THRE];
        s_nxt.thre_pend = (thre_next && !thre_now) || (s_r.thre_pend && !thre_clr);

        // Trigger level in force once this cycle's control write lands
        trig_cnt = CW'(trig_level(s_nxt.trig_sel));

        // Source conditions, each gated by its enable
        src_ls = s_nxt.ie[UFCI_IE_LS] &&
                 (s_nxt.overrun || s_nxt.parity || s_nxt.framing || s_nxt.brk);
        src_rda = s_nxt.ie[UFCI_IE_RDA] && (s_nxt.fifo_en ?
                  (s_nxt.rx_cnt >= trig_cnt) :
                  (s_nxt.rx_cnt != CNT_ZERO));
        src_tmo = s_nxt.ie[UFCI_IE_RDA] && s_nxt.fifo_en &&
                  (s_nxt.tmo_cnt == UFCI_TMO_CHARS);
        src_thre = s_nxt.thre_pend;
        src_ms = s_nxt.ie[UFCI_IE_MS] && (s_nxt.ms_delta != 4'h0);
        id_code = prio_code(src_ls, src_rda, src_tmo, src_thre, src_ms);

        // Identification snapshot holds still during its own read
        if (!iid_rd) begin
            s_nxt.iid = iid_byte(s_nxt.fifo_en, id_code);
        end
        s_nxt.irq = (id_code != UFCI_ID_NONE);

        // Flow indications toward the host side, character toward the transmit shifter
        s_nxt.rx_rdy = (s_nxt.rx_cnt != CNT_ZERO);
        s_nxt.tx_rdy = (s_nxt.tx_cnt == CNT_ZERO);
        s_nxt.tx_valid = (s_nxt.tx_cnt != CNT_ZERO);
        s_nxt.tx_data = s_nxt.tx_mem[s_nxt.tx_rd];

        // Read data, presented in the cycle after the strobe only
        s_nxt.rdata = UFCI_BYTE_ZERO;
        if (rd_in) begin
            case (addr_in)
                UFCI_ADDR_DATA: begin
                    s_nxt.rdata = rx_pop ? s_r.rx_mem[s_r.rx_rd] : UFCI_BYTE_ZERO;
                end
                UFCI_ADDR_IE: begin
                    s_nxt.rdata = {4'h0, s_r.ie};
                end
                UFCI_ADDR_FCTL: begin
                    s_nxt.rdata = s_r.iid;
                end
                UFCI_ADDR_LS: begin
                    s_nxt.rdata = ls_byte(s_r);
                end
                UFCI_ADDR_MS: begin
                    s_nxt.rdata = {modem_in.level, s_r.ms_delta};
                end
                default: begin
                    s_nxt.rdata = UFCI_BYTE_ZERO;
                end
            endcase
        end
    end

    // State register with asynchronous reset to constants
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_r <= '0;
            s_r.ie <= UFCI_IE_RESET;
            s_r.trig_sel <= UFCI_TRIG_RESET;
            s_r.iid <= UFCI_IID_RESET;
            s_r.tx_rdy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign rdata_out = s_r.rdata;
    assign tx_char_out.valid = s_r.tx_valid;
    assign tx_char_out.data = s_r.tx_data;
    assign receive_ready_out = s_r.rx_rdy;
    assign transmit_ready_out = s_r.tx_rdy;
    assign host_interrupt_out = s_r.irq;

endmodule

// ### verification/ufci_chk_sva.sv
// Port checker for the FIFO control and identification block
`timescale 1ns/1ps
module ufci_chk
    import ufci_pkg::*;
#(
    parameter int DEPTH = UFCI_FIFO_DEPTH
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire ufci_rx_char_s rx_char_in,
    input wire ufci_tx_char_s tx_char_out,
    input wire logic receive_ready_out,
    input wire logic transmit_ready_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // Control writes, identification reads and data writes on the bus
    wire fc_wr = wr_in && addr_in == UFCI_ADDR_FCTL;
    wire id_rd = rd_in && addr_in == UFCI_ADDR_FCTL;
    wire tx_wr = wr_in && addr_in == UFCI_ADDR_DATA;

    a_rdata_idle: assert property (!rd_in |=> rdata_out == UFCI_BYTE_ZERO)
        else $error("read data not zero outside a read");
    a_id_fixed_bits: assert property (id_rd |=>
        rdata_out[5:4] == 2'h0 && rdata_out[7] == rdata_out[6])
        else $error("identification upper bits wrong");
    a_id_fifo_code: assert property (id_rd |=> !rdata_out[3] || rdata_out[7])
        else $error("timeout code outside FIFO mode");
    a_id_pending: assert property (id_rd |=>
        rdata_out[0] == (rdata_out[3:0] == UFCI_ID_NONE))
        else $error("pending bit disagrees with code");
    a_tx_ready_valid: assert property (transmit_ready_out == !tx_char_out.valid)
        else $error("transmit ready disagrees with transmit FIFO state");
    a_tx_load: assert property (tx_wr && transmit_ready_out |=> !transmit_ready_out)
        else $error("transmit ready stayed high after load");
    a_rx_push: assert property (rx_char_in.valid && !fc_wr |=> receive_ready_out)
        else $error("receive ready missing after a character");
    a_rx_clear: assert property (fc_wr && wdata_in[0] && wdata_in[1] |=> !receive_ready_out)
        else $error("receive FIFO not emptied");
    a_tx_clear: assert property (fc_wr && wdata_in[0] && wdata_in[2] |=> transmit_ready_out)
        else $error("transmit FIFO not emptied");
    a_legacy_empty: assert property (fc_wr && !wdata_in[0] |=>
        !receive_ready_out && transmit_ready_out)
        else $error("legacy mode left data in a FIFO");

    // Main scenarios reached
    c_rx_clear: cover property (fc_wr && wdata_in[1]);
    c_id_pending: cover property (id_rd ##1 !rdata_out[0]);
    c_tx_load: cover property (tx_wr ##1 !transmit_ready_out);
endmodule

bind ufci_fifo_ctrl_irq_ident ufci_chk #(.DEPTH(DEPTH)) i_chk (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rx_char_in(rx_char_in),
    .tx_char_out(tx_char_out), .receive_ready_out(receive_ready_out),
    .transmit_ready_out(transmit_ready_out)
);

// ### verification/ufci_host_model.sv
// Host processor model driving the register bus
`timescale 1ns/1ps
module ufci_host_model
    import ufci_pkg::*;
(
    input wire logic mclk_in,
    input wire logic [7:0] rdata_in,
    output logic [2:0] addr_out = 3'h0,
    output logic [7:0] wdata_out = 8'h00,
    output logic wr_out = 1'b0,
    output logic rd_out = 1'b0
);
    // One-cycle write; released lines show inverted values
    task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_out <= a;
        wdata_out <= (a == UFCI_ADDR_FCTL) ? (d & 8'hF7) : d;
        wr_out <= 1'b1;
        @(posedge mclk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask

    // One-cycle read; data taken in the cycle after the strobe
    task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge mclk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(posedge mclk_in);
        d = rdata_in;
    endtask
endmodule

// ### verification/tb_uart_fifo_ctrl_irq_ident.sv
// Self-checking bench for the FIFO control and identification block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_uart_fifo_ctrl_irq_ident
    import ufci_pkg::*;
;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] v;
    logic wr;
    logic rd;
    ufci_rx_char_s rx_char = '0;
    ufci_modem_s modem = '0;
    logic tick = 1'b0;
    logic take = 1'b0;
    ufci_tx_char_s tx_char;
    logic rx_rdy;
    logic tx_rdy;
    logic irq;
    int errors = 0;
    int checks = 0;
    int trig [4] = '{1, 4, 8, 14};

    // Free-running 125 MHz clock
    always #4 mclk_in = ~mclk_in;

    ufci_fifo_ctrl_irq_ident i_dut (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rx_char_in(rx_char), .modem_in(modem),
        .char_tick_in(tick), .tx_take_in(take), .tx_char_out(tx_char),
        .receive_ready_out(rx_rdy), .transmit_ready_out(tx_rdy), .host_interrupt_out(irq)
    );

    ufci_host_model i_host (
        .mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd)
    );

    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // Receive shifter delivers one character; data inverted once released
    task automatic push(input logic [7:0] d, input logic perr);
        @(posedge mclk_in);
        rx_char <= '{1'b1, d, perr, 1'b0, 1'b0};
        @(posedge mclk_in);
        rx_char <= '{1'b0, ~d, 1'b0, 1'b0, 1'b0};
    endtask

    task automatic pulse_tick(input int n);
        repeat (n) begin
            @(posedge mclk_in);
            tick <= 1'b1;
            @(posedge mclk_in);
            tick <= 1'b0;
        end
    endtask

    task automatic check_id(input logic [7:0] e);
        cyc(2);
        i_host.read_reg(UFCI_ADDR_FCTL, v);
        `CHK("ident", e, v)
    endtask

    task automatic t_reset;
        check_id(UFCI_IID_RESET);
        `CHK("tx_rdy", 1'b1, tx_rdy)
        i_host.read_reg(3'h7, v);
        `CHK("unmapped", 8'h00, v)
    endtask

    task automatic t_trigger;
        for (int i = 0; i < 4; i++) begin
            i_host.write_reg(UFCI_ADDR_FCTL, {i[1:0], 6'h03});
            i_host.write_reg(UFCI_ADDR_IE, 8'h01);
            repeat (trig[i] - 1) push(8'h30, 1'b0);
            cyc(3);
            `CHK("irq", 1'b0, irq)
            push(8'h31, 1'b0);
            cyc(3);
            `CHK("irq", 1'b1, irq)
            check_id({4'hC, UFCI_ID_RDA});
        end
        `CHK("rx_rdy", 1'b1, rx_rdy)
        i_host.write_reg(UFCI_ADDR_FCTL, 8'h03);
        cyc(1);
        `CHK("rx_rdy", 1'b0, rx_rdy)
        check_id(8'hC1);
    endtask

    task automatic t_timeout;
        i_host.write_reg(UFCI_ADDR_FCTL, 8'h43);
        push(8'h41, 1'b0);
        pulse_tick(3);
        check_id(8'hC1);
        pulse_tick(1);
        check_id({4'hC, UFCI_ID_TMO});
        i_host.write_reg(UFCI_ADDR_IE, 8'h05);
        push(8'h42, 1'b1);
        check_id({4'hC, UFCI_ID_LS});
        i_host.read_reg(UFCI_ADDR_LS, v);
        `CHK("line_status", 8'h65, v)
        check_id(8'hC1);
        i_host.write_reg(UFCI_ADDR_IE, 8'h00);
        push(8'h43, 1'b0);
        push(8'h44, 1'b0);
        check_id(8'hC1);
        `CHK("irq", 1'b0, irq)
        i_host.write_reg(UFCI_ADDR_IE, 8'h01);
        check_id({4'hC, UFCI_ID_RDA});
        i_host.read_reg(UFCI_ADDR_DATA, v);
        `CHK("rx_data", 8'h41, v)
        check_id(8'hC1);
    endtask

    task automatic t_transmit;
        i_host.write_reg(UFCI_ADDR_FCTL, 8'h07);
        i_host.write_reg(UFCI_ADDR_IE, 8'h02);
        check_id({4'hC, UFCI_ID_THRE});
        check_id(8'hC1);
        i_host.write_reg(UFCI_ADDR_DATA, 8'h5A);
        cyc(1);
        `CHK("tx_rdy", 1'b0, tx_rdy)
        `CHK("tx_data", 8'h5A, tx_char.data)
        `CHK("tx_valid", 1'b1, tx_char.valid)
        @(posedge mclk_in);
        take <= 1'b1;
        @(posedge mclk_in);
        take <= 1'b0;
        cyc(1);
        `CHK("tx_rdy", 1'b1, tx_rdy)
        `CHK("tx_valid", 1'b0, tx_char.valid)
        check_id({4'hC, UFCI_ID_THRE});
        i_host.write_reg(UFCI_ADDR_DATA, 8'hA5);
        check_id(8'hC1);
        i_host.write_reg(UFCI_ADDR_FCTL, 8'h05);
        cyc(1);
        `CHK("tx_rdy", 1'b1, tx_rdy)
    endtask

    task automatic t_modem_legacy;
        i_host.write_reg(UFCI_ADDR_IE, 8'h08);
        @(posedge mclk_in);
        modem <= '{4'h0, 4'h1};
        @(posedge mclk_in);
        modem <= '0;
        check_id({4'hC, UFCI_ID_MS});
        i_host.read_reg(UFCI_ADDR_MS, v);
        `CHK("modem_status", 8'h01, v)
        check_id(8'hC1);
        i_host.write_reg(UFCI_ADDR_IE, 8'h01);
        i_host.write_reg(UFCI_ADDR_FCTL, 8'h00);
        check_id(UFCI_IID_RESET);
        push(8'h51, 1'b0);
        pulse_tick(5);
        check_id({4'h0, UFCI_ID_RDA});
        i_host.write_reg(UFCI_ADDR_FCTL, 8'hC6);
        check_id(UFCI_IID_RESET);
    endtask

    // Main sequence
    initial begin
        cyc(16);
        reset_n_in <= 1'b1;
        t_reset();
        t_trigger();
        t_timeout();
        t_transmit();
        t_modem_legacy();
        results();
    end

    // Cuts a hang short
    initial begin
        cyc(20000);
        errors++;
        results();
    end
endmodule
